// >>> verilog/pm_reset_map.svh
`ifndef PM_RESET_MAP_SVH
`define PM_RESET_MAP_SVH

// ****************************************
// Synchroniser lane positions
// ****************************************
`define LANE_POR      0
`define LANE_ISO      1
`define LANE_PCI_RST  2
`define LANE_COUNT    3

// ****************************************
// Timing counts
// ****************************************
`define SYNC_STAGES_DEF  2

// ****************************************
// Reset values of the power management context
// ****************************************
`define AUX_PRESENT_RST  1'b0
`define PME_EN_RST       1'b0
`define PME_STATUS_RST   1'b0
`define DEEP_EN_RST      1'b0
`define ACTIVE_RST       1'b0

`endif

// >>> verilog/pm_reset_pkg.sv
package pm_reset_pkg;

  // ****************************************
  // Device power states
  // ****************************************
  typedef enum logic [1:0] {
    dstate_d0 = 2'b00,
    dstate_d1 = 2'b01,
    dstate_d2 = 2'b10,
    dstate_d3 = 2'b11
  } dstate_e;

endpackage

// >>> verilog/reset_edge_if.sv
`timescale 1ns/10ps

// Synchronised reset levels and release pulses
interface reset_edge_if;
  logic por_act;
  logic iso_act;
  logic pci_rst_act;
  logic iso_rel;
  logic pci_rst_rel;

  modport src (
    output por_act,
    output iso_act,
    output pci_rst_act,
    output iso_rel,
    output pci_rst_rel
  );

  modport dst (
    input  por_act,
    input  iso_act,
    input  pci_rst_act,
    input  iso_rel,
    input  pci_rst_rel
  );
endinterface

// >>> verilog/reset_input_sync.sv
`timescale 1ns/10ps
`include "pm_reset_map.svh"

module reset_input_sync #(
  parameter int SYNC_STAGES = `SYNC_STAGES_DEF
) (
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_i,
  input  wire logic [`LANE_COUNT-1:0]  pin_n_i,
  reset_edge_if.src                    edges
);

  // ****************************************
  // Parameter check
  // ****************************************
  if (SYNC_STAGES < 2) begin : g_bad_stages
    $error("SYNC_STAGES must be at least two");
  end

  logic [`LANE_COUNT-1:0] act;
  logic [`LANE_COUNT-1:0] act_dly;

  // ****************************************
  // One synchroniser chain per reset pin
  // ****************************************
  for (genvar g = 0; g < `LANE_COUNT; g++) begin : g_lane
    logic [SYNC_STAGES-1:0] chain;
    // Reset holds every lane asserted, so release always yields an edge
    always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
        chain <= '1;
      end else begin
        chain <= {chain[SYNC_STAGES-2:0], ~pin_n_i[g]};
      end
    end
    assign act[g] = chain[SYNC_STAGES-1];
  end

  // Delayed copy for edge detection, only of settled stages
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      act_dly <= '1;
    end else begin
      act_dly <= act;
    end
  end

  // Release pulses last exactly one whole cycle
  assign edges.por_act     = act[`LANE_POR];
  assign edges.iso_act     = act[`LANE_ISO];
  assign edges.pci_rst_act = act[`LANE_PCI_RST];
  assign edges.iso_rel     = act_dly[`LANE_ISO] & ~act[`LANE_ISO];
  assign edges.pci_rst_rel = act_dly[`LANE_PCI_RST]
                             & ~act[`LANE_PCI_RST];

  // ****************************************
  // Checks
  // ****************************************
  a_iso_rel_single: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    edges.iso_rel |=> !edges.iso_rel)
    else $error("isolate release pulse longer than one cycle");
  a_rst_rel_clean: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    edges.pci_rst_rel |-> !edges.pci_rst_act && $past(edges.pci_rst_act))
    else $error("reset release pulse without a settled edge");

endmodule

// >>> verilog/nic_power_state_reset_isolation.sv
`timescale 1ns/10ps
`include "pm_reset_map.svh"

module nic_power_state_reset_isolation #(
  parameter int SYNC_STAGES = `SYNC_STAGES_DEF
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        power_on_reset_n_i,
  input  wire logic        isolate_n_i,
  input  wire logic        pci_rst_n_i,
  input  wire logic        flash_addr_bit_one_i,
  input  wire logic        link_valid_i,
  input  wire logic        wake_pkt_match_i,
  input  wire logic        pm_wr_i,
  input  wire logic [1:0]  pm_dstate_i,
  input  wire logic        pm_pme_en_i,
  input  wire logic        pm_pme_clr_i,
  input  wire logic        pm_driver_register_wr_i,
  input  wire logic        pm_driver_register_deep_en_i,
  input  wire logic        bar_wr_i,
  output logic             init_o,
  output logic [1:0]       dstate_o,
  output logic             d0_uninitialized_o,
  output logic             fully_active_state_o,
  output logic             aux_supply_present_o,
  output logic             pm_cap_aux_o,
  output logic             pme_en_o,
  output logic             pme_status_o,
  output logic             pme_n_o,
  output logic             pme_oe_n_o,
  output logic             pci_out_oe_n_o,
  output logic             pci_in_ignore_o,
  output logic             master_en_o,
  output logic             cfg_only_o,
  output logic             link_keepalive_o,
  output logic             deep_link_down_o
);

  // ****************************************
  // Input synchronisation
  // ****************************************
  reset_edge_if edges ();

  reset_input_sync #(
    .SYNC_STAGES (SYNC_STAGES)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .pin_n_i   ({pci_rst_n_i, isolate_n_i, power_on_reset_n_i}),
    .edges     (edges)
  );

  // ****************************************
  // State
  // ****************************************
  pm_reset_pkg::dstate_e dstate;
  logic                  active;
  logic                  pme_en;
  logic                  pme_status;
  logic                  deep_en;
  logic                  aux_present;
  logic                  link_prev;

  // Small decode of the deep states D2 and D3, used once
  function automatic logic is_deep_state(input pm_reset_pkg::dstate_e s);
    return (s == pm_reset_pkg::dstate_d2) || (s == pm_reset_pkg::dstate_d3);
  endfunction

  // ****************************************
  // Reset and isolation decode
  // ****************************************
  wire por_act     = edges.por_act;
  wire iso_act     = edges.iso_act & ~por_act;
  // Isolation hides PCI reset; aux power makes it inert
  wire rst_eff     = edges.pci_rst_act & ~iso_act & ~aux_present;
  wire ignore_pci  = por_act | iso_act | rst_eff;
  wire in_d0       = dstate == pm_reset_pkg::dstate_d0;
  wire in_d1       = dstate == pm_reset_pkg::dstate_d1;
  wire in_d3       = dstate == pm_reset_pkg::dstate_d3;
  wire deep_state  = is_deep_state(dstate);
  wire init_lvl    = rst_eff & ~in_d3;
  wire init_d3     = edges.pci_rst_rel & in_d3
                     & ~iso_act & ~aux_present;
  wire init_iso    = edges.iso_rel;
  wire next_init   = por_act | init_lvl | init_d3 | init_iso;
  // Wake context survives init whenever wake is enabled, except power-on reset, which always clears it
  wire ctx_clear   = por_act | (next_init & ~pme_en);
  wire cfg_ok      = ~ignore_pci;
  // Aux sense is only meaningful while the bus is held in reset
  wire aux_sample  = por_act | edges.pci_rst_act;

  // ****************************************
  // Wake decode
  // ****************************************
  wire link_chg    = link_valid_i ^ link_prev;
  wire pkt_wake    = ~in_d0 & link_valid_i & wake_pkt_match_i;
  wire wake_evt    = pme_en & (link_chg | pkt_wake);
  wire deep_now    = deep_en & deep_state & ~link_valid_i;
  // Integrity kept in D0, or with wake on and a usable link or D1
  wire next_keep   = ~por_act & (in_d0 |
                     (pme_en & (link_valid_i | in_d1)))
                     & ~deep_now;
  wire next_master = in_d0 & active & ~ignore_pci & ~next_init;

  // ****************************************
  // Power state and substate
  // ****************************************
  // Init returns to uninitialised D0; writes ignored while bus is hidden
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      dstate <= pm_reset_pkg::dstate_d0;
      active <= `ACTIVE_RST;
    end else if (next_init) begin
      dstate <= pm_reset_pkg::dstate_d0;
      active <= `ACTIVE_RST;
    end else if (cfg_ok) begin
      if (pm_wr_i) begin
        dstate <= pm_reset_pkg::dstate_e'(pm_dstate_i);
      end
      if (bar_wr_i && in_d0) begin
        active <= 1'b1;
      end
    end
  end

  // ****************************************
  // Wake context
  // ****************************************
  // Event set wins over a write clear in the same cycle; a context clear wins over both
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || ctx_clear) begin
      pme_en     <= `PME_EN_RST;
      pme_status <= `PME_STATUS_RST;
      deep_en    <= `DEEP_EN_RST;
    end else begin
      if (cfg_ok && pm_wr_i) begin
        pme_en <= pm_pme_en_i;
      end
      if (cfg_ok && pm_driver_register_wr_i) begin
        deep_en <= pm_driver_register_deep_en_i;
      end
      if (wake_evt) begin
        pme_status <= 1'b1;
      end else if (cfg_ok && pm_wr_i && pm_pme_clr_i) begin
        pme_status <= 1'b0;
      end
    end
  end

  // Aux sense and link history
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      aux_present <= `AUX_PRESENT_RST;
      link_prev   <= 1'b0;
    end else begin
      if (aux_sample) begin
        aux_present <= flash_addr_bit_one_i;
      end
      link_prev <= link_valid_i;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  // Every output is a flop so the pins never glitch on decode
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      init_o               <= 1'b1;
      dstate_o             <= pm_reset_pkg::dstate_d0;
      d0_uninitialized_o   <= 1'b1;
      fully_active_state_o <= 1'b0;
      aux_supply_present_o <= `AUX_PRESENT_RST;
      pm_cap_aux_o         <= `AUX_PRESENT_RST;
      pme_en_o             <= `PME_EN_RST;
      pme_status_o         <= `PME_STATUS_RST;
      pme_n_o              <= 1'b0;
      pme_oe_n_o           <= 1'b1;
      pci_out_oe_n_o       <= 1'b1;
      pci_in_ignore_o      <= 1'b1;
      master_en_o          <= 1'b0;
      cfg_only_o           <= 1'b0;
      link_keepalive_o     <= 1'b0;
      deep_link_down_o     <= 1'b0;
    end else begin
      init_o               <= next_init;
      dstate_o             <= dstate;
      d0_uninitialized_o   <= in_d0 & ~active;
      // Gated by next_init as well as active, so it never shows beside init
      fully_active_state_o <= in_d0 & active & ~next_init;
      aux_supply_present_o <= aux_present;
      pm_cap_aux_o         <= aux_present;
      pme_en_o             <= pme_en;
      pme_status_o         <= pme_status;
      pme_n_o              <= 1'b0;
      // Wake output stays live even under isolation
      pme_oe_n_o           <= ~(pme_status & pme_en);
      pci_out_oe_n_o       <= ignore_pci;
      pci_in_ignore_o      <= ignore_pci;
      master_en_o          <= next_master;
      cfg_only_o           <= ~in_d0;
      link_keepalive_o     <= next_keep;
      deep_link_down_o     <= deep_now;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_d3_release;
    in_d3 && !aux_present && !iso_act && edges.pci_rst_rel;
  endsequence

  sequence s_held_reset;
    rst_eff && !in_d3;
  endsequence

  a_init_held_reset: assert property (s_held_reset |=> init_o)
    else $error("init missing while reset held in D0-D2");
  a_init_d3_release: assert property (s_d3_release |=> init_o)
    else $error("init missing on reset release in D3");
  a_init_iso_edge: assert property (edges.iso_rel |=> init_o)
    else $error("init missing on isolate release");
  a_aux_blocks_rst: assert property (aux_present && !por_act
    && !edges.iso_rel |=> !init_o)
    else $error("PCI reset acted with aux power present");
  a_iso_floats: assert property (iso_act |=> pci_out_oe_n_o
    && pci_in_ignore_o)
    else $error("PCI outputs driven while isolated");
  a_iso_keeps_pme: assert property (iso_act && pme_en && pme_status
    |=> !pme_oe_n_o)
    else $error("wake output dropped while isolated");
  a_rst_floats: assert property (rst_eff |=> pci_out_oe_n_o)
    else $error("PCI outputs driven during PCI reset");
  a_ctx_kept: assert property (rst_eff && pme_en && !por_act
    |=> pme_en && $past(pme_status) <= pme_status)
    else $error("wake context lost on PCI reset");
  a_no_wake_off: assert property (!in_d0 && !pme_en && !por_act
    |=> !link_keepalive_o && !$rose(pme_status))
    else $error("wake or integrity active with wake disabled");
  a_deep_quiet: assert property (deep_now |=> deep_link_down_o
    && !link_keepalive_o)
    else $error("link pulses sent in deep link-down mode");
  a_link_wake: assert property (pme_en && link_chg && !ctx_clear
    |=> pme_status ##1 pme_status_o)
    else $error("link change did not raise wake");
  a_aux_sample: assert property (aux_sample
    |=> aux_present == $past(flash_addr_bit_one_i) ##1 pm_cap_aux_o
    == $past(aux_present))
    else $error("aux sense not captured during reset");
  a_init_d0u: assert property (init_o |-> !fully_active_state_o)
    else $error("fully active during init");
  a_no_master: assert property (!in_d0 |=> !master_en_o && cfg_only_o)
    else $error("initiator enabled outside D0");

  // Packet wake only counts with a usable link outside D0
  sequence s_pkt_event;
    pme_en && pkt_wake && !ctx_clear;
  endsequence

  // A hidden bus must leave state and substate untouched
  a_pkt_wake: assert property (s_pkt_event |=> pme_status)
    else $error("wake packet did not raise wake");
  a_cfg_blocked: assert property (ignore_pci && !next_init
    |=> $stable(dstate) && $stable(active))
    else $error("configuration write taken while bus ignored");
  a_d3_level_quiet: assert property (in_d3 && rst_eff && !por_act
    && !edges.iso_rel |=> !init_o)
    else $error("reset level initialised the device in D3");
  a_master_d0a: assert property (master_en_o |-> fully_active_state_o)
    else $error("initiator enabled outside the active substate");

endmodule

// >>> test/pm_host_model.sv
`timescale 1ns/10ps

// ****************************************
// Host bus power and platform reset model
// ****************************************
module pm_host_model #(
  parameter int RST_GAP = 4
) (
  input  wire logic clk_sys_i,
  input  wire logic bus_power_good_i,
  input  wire logic warm_boot_i,
  input  wire logic aux_fitted_i,
  input  wire logic aux_power_good_i,
  output logic      power_on_reset_n_o,
  output logic      isolate_n_o,
  output logic      pci_rst_n_o,
  output logic      aux_sense_o
);
  int gap;

  // Isolate follows bus power; reset trails it so power good envelopes it
  always_ff @(posedge clk_sys_i) begin
    isolate_n_o        <= bus_power_good_i;
    gap                <= !bus_power_good_i ? 0 :
                          (gap < RST_GAP) ? gap + 1 : gap;
    pci_rst_n_o        <= bus_power_good_i && (gap >= RST_GAP) &&
                          !warm_boot_i;
    power_on_reset_n_o <= aux_power_good_i;
  end

  // Pull-up only on aux-fed boards; an unfitted pin reads low here
  assign aux_sense_o = aux_fitted_i;
  // No crossover peer is modelled, so deep mode stays under bench control
endmodule

// >>> test/nic_power_state_reset_isolation_test.sv
`timescale 1ns/10ps

module nic_power_state_reset_isolation_test;
  logic       clk_sys_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       pwr_good = 1'b1, warm_boot = 1'b0, aux_fit = 1'b0;
  logic       aux_good = 1'b1, link_valid = 1'b1, pkt = 1'b0;
  logic       pm_wr = 1'b0, pme_en = 1'b0, pme_clr = 1'b0;
  logic       drv_wr = 1'b0, deep_en = 1'b0, bar_wr = 1'b0;
  logic [1:0] dst = 2'h0;
  wire logic  por_n, iso_n, prst_n, aux_pin;
  logic       init_o, d0u, fa, aux_p, cap_aux, pme_en_q, pme_st;
  logic       pme_oe_n, out_oe_n, in_ign, mst, cfg, keep, deep, pme_pin;
  logic [1:0] dstate;
  int         miscompares = 0, n_tests = 0, cycles = 0;

  // ****************************************
  // Clock, far side and design
  // ****************************************
  always #2 clk_sys_i = ~clk_sys_i;

  pm_host_model u_host (.clk_sys_i(clk_sys_i), .bus_power_good_i(pwr_good),
    .warm_boot_i(warm_boot), .aux_fitted_i(aux_fit),
    .aux_power_good_i(aux_good), .power_on_reset_n_o(por_n),
    .isolate_n_o(iso_n), .pci_rst_n_o(prst_n), .aux_sense_o(aux_pin));

  nic_power_state_reset_isolation u_dut (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .power_on_reset_n_i(por_n), .isolate_n_i(iso_n),
    .pci_rst_n_i(prst_n), .flash_addr_bit_one_i(aux_pin),
    .link_valid_i(link_valid), .wake_pkt_match_i(pkt), .pm_wr_i(pm_wr),
    .pm_dstate_i(dst), .pm_pme_en_i(pme_en), .pm_pme_clr_i(pme_clr),
    .pm_driver_register_wr_i(drv_wr),
    .pm_driver_register_deep_en_i(deep_en), .bar_wr_i(bar_wr),
    .init_o(init_o), .dstate_o(dstate), .d0_uninitialized_o(d0u),
    .fully_active_state_o(fa), .aux_supply_present_o(aux_p),
    .pm_cap_aux_o(cap_aux), .pme_en_o(pme_en_q), .pme_status_o(pme_st),
    .pme_n_o(pme_pin), .pme_oe_n_o(pme_oe_n), .pci_out_oe_n_o(out_oe_n),
    .pci_in_ignore_o(in_ign), .master_en_o(mst), .cfg_only_o(cfg),
    .link_keepalive_o(keep), .deep_link_down_o(deep));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic chk(input string what, input logic [1:0] exp,
                     input logic [1:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // One-cycle strobe, then three edges for state and output to follow
  task automatic pm_write(input logic [1:0] d, input logic en,
                          input logic clr);
    @(posedge clk_sys_i);
    pm_wr   <= 1'b1;
    dst     <= d;
    pme_en  <= en;
    pme_clr <= clr;
    @(posedge clk_sys_i);
    pm_wr   <= 1'b0;
    pme_clr <= 1'b0;
    tick(3);
  endtask

  task automatic drv_write(input logic e);
    @(posedge clk_sys_i);
    drv_wr  <= 1'b1;
    deep_en <= e;
    @(posedge clk_sys_i);
    drv_wr  <= 1'b0;
    tick(3);
  endtask

  // Counts init cycles over a window; read at the edge, before its update
  task automatic watch_init(input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      @(posedge clk_sys_i);
      cnt += int'(init_o === 1'b1);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    int i;
    tick(19);
    #1 chk("init", 1, init_o);
    chk("oe_n", 1, out_oe_n);
    @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (i = 0; i < 40 && in_ign !== 1'b0; i++) tick(1);
    tick(2);
    chk("d0u", 1, d0u);
    chk("oe_n", 0, out_oe_n);
    $display("test reset done");
  endtask

  task automatic t_states();
    int d;
    for (d = 0; d < 4; d++) begin
      pm_write(2'(d), 1'b0, 1'b0);
      chk("dstate", 2'(d), dstate);
      chk("cfg_only", {1'b0, d != 0}, cfg);
      if (d != 0) chk("master", 0, mst);
    end
    pm_write(2'h0, 1'b0, 1'b0);
    @(posedge clk_sys_i);
    bar_wr <= 1'b1;
    @(posedge clk_sys_i);
    bar_wr <= 1'b0;
    tick(3);
    chk("active", 1, fa);
    chk("d0u", 0, d0u);
    chk("master", 1, mst);
    $display("test states done");
  endtask

  task automatic t_link_wake();
    link_valid <= 1'b0;
    tick(5);
    chk("status", 0, pme_st);
    pm_write(2'h0, 1'b1, 1'b0);
    link_valid <= 1'b1;
    tick(5);
    chk("status", 1, pme_st);
    chk("pme_oe", 0, pme_oe_n);
    pm_write(2'h0, 1'b1, 1'b1);
    chk("status", 0, pme_st);
    link_valid <= 1'b0;
    tick(5);
    chk("status", 1, pme_st);
    link_valid <= 1'b1;
    pm_write(2'h1, 1'b1, 1'b1);
    tick(2);
    pm_write(2'h1, 1'b1, 1'b1);
    chk("keep", 1, keep);
    pkt <= 1'b1;
    tick(1);
    pkt <= 1'b0;
    tick(4);
    chk("status", 1, pme_st);
    pm_write(2'h0, 1'b0, 1'b1);
    $display("test link wake done");
  endtask

  task automatic t_deep();
    int d;
    for (d = 2; d < 4; d++) begin
      drv_write(1'b1);
      link_valid <= 1'b0;
      pm_write(2'(d), 1'b1, 1'b0);
      chk("deep", 1, deep);
      chk("keep", 0, keep);
      drv_write(1'b0);
      chk("deep", 0, deep);
      link_valid <= 1'b1;
      pm_write(2'(d), 1'b0, 1'b1);
      chk("keep", 0, keep);
    end
    pm_write(2'h0, 1'b0, 1'b1);
    $display("test deep done");
  endtask

  task automatic t_warm();
    int cnt;
    warm_boot <= 1'b1;
    tick(6);
    chk("init", 1, init_o);
    chk("ignore", 1, in_ign);
    pm_write(2'h1, 1'b0, 1'b0);
    chk("dstate", 0, dstate);
    chk("init", 1, init_o);
    warm_boot <= 1'b0;
    tick(8);
    chk("init", 0, init_o);
    chk("oe_n", 0, out_oe_n);
    // In D3 the reset level is quiet; only its release initialises
    pm_write(2'h3, 1'b1, 1'b0);
    warm_boot <= 1'b1;
    tick(6);
    chk("init", 0, init_o);
    chk("ignore", 1, in_ign);
    warm_boot <= 1'b0;
    watch_init(12, cnt);
    chk("init count", 1, 2'(cnt));
    chk("dstate", 0, dstate);
    chk("pme_en", 1, pme_en_q);
    pm_write(2'h0, 1'b0, 1'b1);
    $display("test warm reset done");
  endtask

  task automatic t_b3();
    int cnt;
    pm_write(2'h3, 1'b1, 1'b0);
    pwr_good <= 1'b0;
    tick(6);
    chk("oe_n", 1, out_oe_n);
    chk("ignore", 1, in_ign);
    pm_write(2'h1, 1'b1, 1'b0);
    chk("dstate", 3, dstate);
    link_valid <= 1'b0;
    tick(5);
    chk("pme_oe", 0, pme_oe_n);
    chk("pme_pin", 0, pme_pin);
    pwr_good <= 1'b1;
    watch_init(20, cnt);
    chk("init seen", 1, {1'b0, cnt > 0});
    chk("dstate", 0, dstate);
    chk("pme_en", 1, pme_en_q);
    chk("pme_oe", 0, pme_oe_n);
    link_valid <= 1'b1;
    tick(4);
    pm_write(2'h0, 1'b0, 1'b1);
    chk("status", 0, pme_st);
    $display("test isolate done");
  endtask

  task automatic t_aux();
    int cnt;
    aux_fit   <= 1'b1;
    warm_boot <= 1'b1;
    tick(10);
    warm_boot <= 1'b0;
    tick(10);
    chk("aux", 1, aux_p);
    chk("cap_aux", 1, cap_aux);
    pm_write(2'h1, 1'b0, 1'b0);
    warm_boot <= 1'b1;
    watch_init(12, cnt);
    chk("init count", 0, 2'(cnt));
    chk("dstate", 1, dstate);
    warm_boot <= 1'b0;
    aux_good  <= 1'b0;
    tick(8);
    chk("init", 1, init_o);
    chk("dstate", 0, dstate);
    aux_good  <= 1'b1;
    tick(10);
    $display("test aux done");
  endtask

  // ****************************************
  // Hang guard and main sequence
  // ****************************************
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    t_reset();
    t_states();
    t_link_wake();
    t_deep();
    t_warm();
    t_b3();
    t_aux();
    test_done();
  end
endmodule
